//--- hdl/sbi_pkg.sv
package sbi_pkg;

  // ****************************************************************
  // register map (index on the 3-bit register port)
  // ****************************************************************
  localparam logic [2:0] SBI_REG_MODE = 3'h0;
  localparam logic [2:0] SBI_REG_BUSCTL = 3'h1;
  localparam logic [2:0] SBI_REG_ITIME = 3'h2;
  localparam logic [2:0] SBI_REG_SHIFT = 3'h3;
  localparam logic [2:0] SBI_REG_SVA = 3'h4;
  localparam logic [2:0] SBI_REG_STAT = 3'h5;

  // ****************************************************************
  // field positions
  // ****************************************************************
  // channel_mode_reg
  localparam int SBI_MODE_EN = 7;
  localparam int SBI_MODE_MATCH = 6;
  localparam int SBI_MODE_WUP = 5;
  localparam int SBI_MODE_MASTER = 1;
  // bus_control_reg
  localparam int SBI_BC_SYNC_BUSY_ENABLE = 7;
  localparam int SBI_BC_ACK_DETECT_FLAG = 6;
  localparam int SBI_BC_ACK_AUTO_ENABLE = 5;
  localparam int SBI_BC_ACK_TRIGGER = 4;
  localparam int SBI_BC_COMMAND_DETECT_FLAG = 3;
  localparam int SBI_BC_RELEASE_DETECT_FLAG = 2;
  localparam int SBI_BC_COMMAND_TRIGGER = 1;
  localparam int SBI_BC_RELEASE_TRIGGER = 0;
  // interrupt_timing_reg
  localparam int SBI_IT_CLD = 6;
  localparam int SBI_IT_RIS = 5;
  // status register
  localparam int SBI_ST_IRQ = 0;
  localparam int SBI_ST_CLASS = 1;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] SBI_RST_REG = 8'h00;
  localparam logic [7:0] SBI_RST_SHIFT = 8'hff;
  localparam logic [3:0] SBI_BITS_PER_BYTE = 4'h8;

  // ****************************************************************
  // master clock timing
  // ****************************************************************
  localparam int SBI_CLK_MHZ = 250;
  localparam int SBI_SCK_HALF_NS = 500;
  localparam int SBI_SCK_HALF_CYC = (SBI_SCK_HALF_NS * SBI_CLK_MHZ) / 1000;

  // byte classes
  localparam logic [1:0] SBI_CLS_DATA = 2'h0;
  localparam logic [1:0] SBI_CLS_CMD = 2'h1;
  localparam logic [1:0] SBI_CLS_ADDR = 2'h2;

  // transfer engine states, gray along idle-wait-shift
  typedef enum logic [1:0] {
    SBI_IDLE = 2'b00,
    SBI_WAIT = 2'b01,
    SBI_SHIFT = 2'b11
  } sbi_state_e;

endpackage : sbi_pkg

//--- hdl/sbi_pin_sync.sv
`timescale 1ns/1ns
module sbi_pin_sync #(
  parameter int W = 2
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] lvl,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] lvl_q;
  logic [W-1:0] agree;

  // three-stage sampling of outside levels
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
      lvl_q <= '1;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= (agree & s3_q) | (~agree & lvl_q);
    end
  end

  // a change counts once stages two and three agree
  assign agree = ~(s2_q ^ s3_q);
  assign rise = agree & s3_q & ~lvl_q;
  assign fall = agree & ~s3_q & lvl_q;
  assign lvl = lvl_q;

endmodule : sbi_pin_sync

//--- hdl/sbi_core.sv
// How it works
// RULE_01: busy low at fall after acknowledge
// RULE_02: clearing busy enable releases at next fall
// RULE_03: transfer start ends busy, enable kept
// RULE_04: timing register byte writable, resets zero
// RULE_05: clock level bit read-only, zero when disabled
// RULE_06: software writes zeros to low nibble
// RULE_07: software sets ack trigger only after byte
// RULE_08: rising data while clock high: release
// RULE_09: falling data while clock high: command
// RULE_10: receiver acknowledges low one clock period
// RULE_11: line left high around transfers
// RULE_12: eight data clocks, then acknowledge and busy
// RULE_13: no wake-up: flag at ninth rise
// RULE_14: wake-up: flag only on address match
// RULE_15: classify byte as address, command, data
// RULE_16: start during busy waits for ready line
// RULE_17: clock push-pull as master, open-drain data
// RULE_18: wake-up keeps data output floating
// RULE_19: release select: interrupt on release instead; without wake-up the code also flags at the ninth rise
// RULE_20: shift register captures actual line levels
// RULE_21: match flag compares address and shift register
// RULE_22: shift on fall msb first, sample on rise
// RULE_23: software judges selection by address interrupt
// RULE_24: release/command triggers set/clear output latch
// RULE_25: auto acknowledge at ninth falling edge
// RULE_26: acknowledge detect at rise, cleared when disabled
`timescale 1ns/1ns
module sbi_core
  import sbi_pkg::*;
#(
  parameter int SCK_HALF_CYC = SBI_SCK_HALF_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output logic transfer_irq_flag,
  output logic transfer_interrupt
);

  // ****************************************************************
  // register state
  // ****************************************************************
  logic channel_enable_q;
  logic wakeup_enable_q;
  logic master_q;
  logic [4:0] mode_low_q;
  logic sync_busy_enable_q;
  logic ack_auto_enable_q;
  logic ack_trigger_q;
  logic ack_trigger_d;
  logic release_detect_q;
  logic release_detect_d;
  logic command_detect_q;
  logic command_detect_d;
  logic ack_detect_q;
  logic ack_detect_d;
  logic [7:0] itime_q;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic [7:0] sva_q;
  logic irq_q;
  logic irq_d;
  logic [1:0] class_q;
  logic [7:0] rdata_q;

  // ****************************************************************
  // engine state
  // ****************************************************************
  sbi_state_e state_q;
  sbi_state_e state_d;
  logic [3:0] cnt_q;
  logic output_latch_q;
  logic output_latch_d;
  logic ack_out_q;
  logic ack_out_d;
  logic busy_q;
  logic busy_d;
  logic msck_q;
  logic [15:0] div_q;

  // ****************************************************************
  // pins and edges
  // ****************************************************************
  logic [1:0] pin_lvl;
  logic [1:0] pin_rise;
  logic [1:0] pin_fall;
  logic sda_lvl;
  logic sck_lvl;
  logic sck_rise;
  logic sck_fall;
  logic m_tick;
  logic m_rise;
  logic m_fall;
  logic rel_evt;
  logic cmd_evt;

  sbi_pin_sync #(
    .W(2)
  ) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .pin({sda_in, sck_in}),
    .lvl(pin_lvl),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  // serial clock: own divider as master, sampled pin as slave
  assign m_tick = (div_q == 16'(SCK_HALF_CYC - 1));
  assign m_rise = m_tick & ~msck_q;
  assign m_fall = m_tick & msck_q;
  assign sck_lvl = master_q ? msck_q : pin_lvl[0];
  assign sck_rise = channel_enable_q & (master_q ? m_rise : pin_rise[0]);
  assign sck_fall = channel_enable_q & (master_q ? m_fall : pin_fall[0]);
  assign sda_lvl = pin_lvl[1];
  // data edges while clock is high mark release and command
  assign rel_evt = channel_enable_q & pin_rise[1] & sck_lvl; // [RULE_08]
  assign cmd_evt = channel_enable_q & pin_fall[1] & sck_lvl; // [RULE_09]

  // ****************************************************************
  // register port decode
  // ****************************************************************
  logic wr_mode;
  logic wr_busctl;
  logic wr_itime;
  logic wr_shift;
  logic wr_sva;
  logic wr_stat;
  logic start_wr;
  logic active;
  logic ninth_rise;
  logic ninth_fall;
  logic is_addr;
  logic addr_match;
  logic ris;
  logic byte_irq;
  logic rel_irq;
  logic mismatch;
  logic clock_level;
  logic [7:0] rd_mux;

  assign wr_mode = wr && (addr == SBI_REG_MODE);
  assign wr_busctl = wr && (addr == SBI_REG_BUSCTL);
  assign wr_itime = wr && (addr == SBI_REG_ITIME);
  assign wr_shift = wr && (addr == SBI_REG_SHIFT);
  assign wr_sva = wr && (addr == SBI_REG_SVA);
  assign wr_stat = wr && (addr == SBI_REG_STAT);
  // a shift register write starts a transfer while the channel is enabled, unless one is shifting
  assign start_wr = wr_shift & channel_enable_q & (state_q != SBI_SHIFT);
  assign active = (state_q == SBI_SHIFT);
  assign ninth_rise = sck_rise & active & (cnt_q == SBI_BITS_PER_BYTE); // [RULE_12]
  assign ninth_fall = sck_fall & active & (cnt_q == SBI_BITS_PER_BYTE); // [RULE_12]
  assign is_addr = release_detect_q & command_detect_q; // [RULE_15]
  assign addr_match = channel_enable_q & (sva_q == shift_q); // [RULE_21]
  assign ris = itime_q[SBI_IT_RIS];
  // release select overrides address-match wake-up
  assign byte_irq = wakeup_enable_q ? (~ris & is_addr & addr_match) : 1'b1; // [RULE_13] [RULE_14]
  assign rel_irq = ris & rel_evt; // [RULE_19]
  assign mismatch = ninth_rise & wakeup_enable_q & ~ris & is_addr & ~addr_match; // [RULE_14]
  assign clock_level = channel_enable_q & sck_lvl; // [RULE_05]

  // read mux, unmapped reads return zero
  assign rd_mux =
    (addr == SBI_REG_MODE) ?
      {channel_enable_q, addr_match, wakeup_enable_q, mode_low_q} :
    (addr == SBI_REG_BUSCTL) ?
      {sync_busy_enable_q, ack_detect_q, ack_auto_enable_q, ack_trigger_q,
       command_detect_q, release_detect_q, 2'b00} :
    (addr == SBI_REG_ITIME) ?
      {itime_q[7], clock_level, itime_q[5:0]} :
    (addr == SBI_REG_SHIFT) ? shift_q :
    (addr == SBI_REG_SVA) ? sva_q :
    (addr == SBI_REG_STAT) ? {5'b00000, class_q, irq_q} : 8'h00;

  // ****************************************************************
  // software registers
  // ****************************************************************
  // mode, control and timing registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      channel_enable_q <= 1'b0;
      wakeup_enable_q <= 1'b0;
      master_q <= 1'b0;
      mode_low_q <= 5'h00;
      sync_busy_enable_q <= 1'b0;
      ack_auto_enable_q <= 1'b0;
      itime_q <= SBI_RST_REG; // [RULE_04]
      sva_q <= SBI_RST_REG;
      rdata_q <= SBI_RST_REG;
    end else begin
      if (wr_mode) begin
        channel_enable_q <= wdata[SBI_MODE_EN];
        wakeup_enable_q <= wdata[SBI_MODE_WUP];
        master_q <= wdata[SBI_MODE_MASTER];
        mode_low_q <= wdata[4:0];
      end
      if (wr_busctl) begin
        sync_busy_enable_q <= wdata[SBI_BC_SYNC_BUSY_ENABLE];
        ack_auto_enable_q <= wdata[SBI_BC_ACK_AUTO_ENABLE];
      end
      // bit 6 is never stored; low nibble is taken as written
      if (wr_itime) begin
        itime_q <= {wdata[7], 1'b0, wdata[5:0]}; // [RULE_04] [RULE_06]
      end
      if (wr_sva) begin
        sva_q <= wdata;
      end
      rdata_q <= rd ? rd_mux : SBI_RST_REG;
    end
  end

  // ****************************************************************
  // flags: set wins over every clear, except the ack trigger, where clear wins
  // ****************************************************************
  always_comb begin
    release_detect_d = release_detect_q;
    if (start_wr || mismatch || cmd_evt) begin
      release_detect_d = (start_wr || mismatch) ? 1'b0 : release_detect_q;
    end
    if (!channel_enable_q) begin
      release_detect_d = 1'b0;
    end else if (rel_evt) begin
      release_detect_d = 1'b1; // [RULE_08]
    end
    command_detect_d = command_detect_q;
    if (start_wr || rel_evt || !channel_enable_q) begin
      command_detect_d = 1'b0; // [RULE_08]
    end
    if (cmd_evt) begin
      command_detect_d = 1'b1; // [RULE_09]
    end
    ack_detect_d = ack_detect_q;
    if (start_wr || !channel_enable_q) begin
      ack_detect_d = 1'b0; // [RULE_26]
    end
    if (ninth_rise && !sda_lvl) begin
      ack_detect_d = 1'b1; // [RULE_10] [RULE_26]
    end
    ack_trigger_d = ack_trigger_q;
    if (wr_busctl && wdata[SBI_BC_ACK_TRIGGER]) begin
      ack_trigger_d = 1'b1;
    end
    if (start_wr || !channel_enable_q || (sck_fall && !active && ack_trigger_q)) begin
      ack_trigger_d = 1'b0;
    end
    irq_d = irq_q;
    if (wr_stat && wdata[SBI_ST_IRQ]) begin
      irq_d = 1'b0;
    end
    if ((ninth_rise && byte_irq) || rel_irq) begin
      irq_d = 1'b1; // [RULE_13] [RULE_14] [RULE_19]
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      release_detect_q <= 1'b0;
      command_detect_q <= 1'b0;
      ack_detect_q <= 1'b0;
      ack_trigger_q <= 1'b0;
      irq_q <= 1'b0;
      class_q <= SBI_CLS_DATA;
    end else begin
      release_detect_q <= release_detect_d;
      command_detect_q <= command_detect_d;
      ack_detect_q <= ack_detect_d;
      ack_trigger_q <= ack_trigger_d;
      irq_q <= irq_d;
      if (ninth_rise) begin
        class_q <= is_addr ? SBI_CLS_ADDR :
                   command_detect_q ? SBI_CLS_CMD : SBI_CLS_DATA; // [RULE_15]
      end
    end
  end

  // ****************************************************************
  // transfer engine
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    shift_d = shift_q;
    output_latch_d = output_latch_q;
    ack_out_d = ack_out_q;
    busy_d = busy_q;
    case (state_q)
      SBI_IDLE: begin
        if (start_wr) begin
          state_d = SBI_WAIT;
        end
      end
      SBI_WAIT: begin
        // held back until the line reads ready
        if (sda_lvl) begin
          state_d = SBI_SHIFT; // [RULE_16]
        end
      end
      SBI_SHIFT: begin
        if (ninth_rise) begin
          state_d = SBI_IDLE;
        end
      end
      default: begin
        state_d = SBI_IDLE;
      end
    endcase
    if (sck_fall && active && cnt_q < SBI_BITS_PER_BYTE) begin
      output_latch_d = shift_q[7]; // [RULE_22]
    end
    if (sck_rise && active && cnt_q < SBI_BITS_PER_BYTE) begin
      shift_d = {shift_q[6:0], sda_lvl}; // [RULE_20] [RULE_22]
    end
    if (ninth_fall) begin
      output_latch_d = 1'b1; // [RULE_11]
      ack_out_d = ack_auto_enable_q; // [RULE_25]
    end
    if (sck_fall && !active && ack_trigger_q) begin
      ack_out_d = 1'b1; // [RULE_10]
    end
    if (sck_fall && ack_out_q) begin
      ack_out_d = 1'b0; // [RULE_10]
      busy_d = sync_busy_enable_q; // [RULE_01]
    end
    if (sck_fall && !sync_busy_enable_q) begin
      busy_d = 1'b0; // [RULE_02]
    end
    if (wr_busctl && channel_enable_q && wdata[SBI_BC_RELEASE_TRIGGER]) begin
      output_latch_d = 1'b1; // [RULE_24]
    end
    if (wr_busctl && channel_enable_q && wdata[SBI_BC_COMMAND_TRIGGER]) begin
      output_latch_d = 1'b0; // [RULE_24]
    end
    if (wr_shift && !active) begin
      shift_d = wdata;
    end
    if (start_wr) begin
      busy_d = 1'b0; // [RULE_03] [RULE_11]
    end
    if (!channel_enable_q) begin
      state_d = SBI_IDLE;
      ack_out_d = 1'b0;
      busy_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= SBI_IDLE;
      shift_q <= SBI_RST_SHIFT;
      output_latch_q <= 1'b1;
      ack_out_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      shift_q <= shift_d;
      output_latch_q <= output_latch_d;
      ack_out_q <= ack_out_d;
      busy_q <= busy_d;
    end
  end

  // bit counter, counts serial clock rises in a transfer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 4'h0;
    end else if (!active) begin
      cnt_q <= 4'h0;
    end else if (sck_rise) begin
      cnt_q <= cnt_q + 4'h1; // [RULE_12]
    end
  end

  // master clock divider, runs only during a transfer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_q <= 16'h0000;
      msck_q <= 1'b1;
    end else if (!(master_q && active)) begin
      div_q <= 16'h0000;
      msck_q <= 1'b1;
    end else if (m_tick) begin
      div_q <= 16'h0000;
      msck_q <= ~msck_q;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // data pin only ever pulls low; wake-up masks the data term
  assign sda_out = 1'b0;
  assign sda_oe_n = ~(channel_enable_q &
                      ((~output_latch_q & ~wakeup_enable_q) | ack_out_q | busy_q)); // [RULE_17] [RULE_18]
  assign sck_out = msck_q;
  assign sck_oe_n = ~(channel_enable_q & master_q); // [RULE_17]
  assign rdata = rdata_q;
  assign transfer_irq_flag = irq_q;
  assign transfer_interrupt = irq_d & ~irq_q;

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_busy_after_ack: assert property (@(posedge clk) disable iff (!arst_n) // [RULE_01]
    sck_fall && ack_out_q && sync_busy_enable_q && channel_enable_q && !start_wr
    |=> busy_q && !sda_oe_n)
    else $error("busy not driven after acknowledge");

  a_busy_release: assert property (@(posedge clk) disable iff (!arst_n) // [RULE_02]
    sck_fall && !sync_busy_enable_q |=> !busy_q)
    else $error("busy not released at falling edge");

  a_start_busy: assert property (@(posedge clk) disable iff (!arst_n) // [RULE_03]
    start_wr && !wr_busctl |=> !busy_q && sync_busy_enable_q == $past(sync_busy_enable_q))
    else $error("transfer start did not end busy or changed enable");

  a_cld_zero: assert property (@(posedge clk) disable iff (!arst_n) // [RULE_05]
    rd && addr == SBI_REG_ITIME && !channel_enable_q |=> !rdata[SBI_IT_CLD])
    else $error("clock level bit read one while disabled");

  a_rel_flags: assert property (@(posedge clk) disable iff (!arst_n) // [RULE_08]
    rel_evt |=> release_detect_q && !command_detect_q)
    else $error("release detect flags wrong");

  a_irq_ninth: assert property (@(posedge clk) disable iff (!arst_n) // [RULE_13]
    ninth_rise && !wakeup_enable_q |=> irq_q && state_q == SBI_IDLE)
    else $error("transfer flag not set at ninth rise");

  a_wait_ready: assert property (@(posedge clk) disable iff (!arst_n) // [RULE_16]
    state_q == SBI_WAIT && !sda_lvl && channel_enable_q |=> state_q == SBI_WAIT)
    else $error("transfer started while line busy");

  a_shift_msb: assert property (@(posedge clk) disable iff (!arst_n) // [RULE_22]
    sck_fall && active && cnt_q < SBI_BITS_PER_BYTE && !wr_busctl
    |=> output_latch_q == $past(shift_q[7]))
    else $error("output latch not loaded with msb");

  a_ack_ninth: assert property (@(posedge clk) disable iff (!arst_n) // [RULE_25]
    ninth_fall && ack_auto_enable_q |=> ack_out_q && !sda_oe_n)
    else $error("auto acknowledge missing at ninth fall");

  a_ack_detect: assert property (@(posedge clk) disable iff (!arst_n) // [RULE_26]
    ninth_rise && !sda_lvl |=> ack_detect_q)
    else $error("acknowledge not detected");

endmodule : sbi_core

//--- tb/sbi_far_master.sv
`timescale 1ns/1ns
// ****************************************
// far-side bus master: push-pull clock, open-drain data
// ****************************************
module sbi_far_master (
  input wire logic dev_oe_n,
  output logic sck,
  output logic line
);
  logic m_low;

  // wired-and data line with pull-up
  assign line = !(m_low || !dev_oe_n);

  initial begin
    sck = 1'b1;
    m_low = 1'b0;
  end

  // cmd, release, cmd with the clock held high
  task automatic frame;
    m_low = 1'b1;
    #62;
    m_low = 1'b0;
    #62;
    m_low = 1'b1;
    #62;
  endtask : frame

  // eight data clocks then the acknowledge clock
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sck = 1'b0;
      #31;
      m_low = ~tx[i];
      #31;
      sck = 1'b1;
      rx[i] = line;
      #63;
    end
    sck = 1'b0;
    #31;
    m_low = 1'b0;
    #31;
    sck = 1'b1;
    ack = ~line;
    #63;
  endtask : xfer

  // hold or free the data line outside a transfer
  task automatic hold(input logic low);
    m_low = low;
  endtask : hold

  // one extra clock, line seen while low
  task automatic clk1(output logic lvl);
    sck = 1'b0;
    #62;
    lvl = line;
    sck = 1'b1;
    #63;
  endtask : clk1
endmodule : sbi_far_master

//--- tb/tb.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb
  import sbi_pkg::*;
;
  logic clk, arst_n, wr, rd, sck, line, sda_oe_n, irq, ack, lvl;
  logic sck_o, sck_oe_n, sda_o, pulse;
  int n_pulse;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, v, rx;
  int n_fail, comparisons;

  // half period of eight clocks leaves room for the data pin sampling delay
  sbi_core #(.SCK_HALF_CYC(8)) dut (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .sck_in(sck), .sck_out(sck_o), .sck_oe_n(sck_oe_n),
    .sda_in(line), .sda_out(sda_o), .sda_oe_n(sda_oe_n), .transfer_irq_flag(irq),
    .transfer_interrupt(pulse));
  sbi_far_master far (.dev_oe_n(sda_oe_n), .sck(sck), .line(line));

  // count one-cycle interrupt pulses
  always @(posedge clk) begin
    if (pulse === 1'b1) begin
      n_pulse <= n_pulse + 1;
    end
  end

  // ****************************************
  // bus tasks
  // ****************************************
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg

  task automatic rreg(input logic [2:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rreg

  task automatic reset_dut;
    arst_n = 1'b0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask : reset_dut

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs;
    reset_dut;
    rreg(SBI_REG_ITIME);
    `CHK("itime reset", 8'h00, v)
    wreg(SBI_REG_ITIME, 8'h60);
    rreg(SBI_REG_ITIME);
    `CHK("itime clock level", 8'h20, v)
    wreg(SBI_REG_MODE, 8'h80);
    rreg(SBI_REG_ITIME);
    `CHK("clock level enabled", 8'h60, v)
    `CHK("clock not driven", 1'b1, sck_oe_n)
    wreg(SBI_REG_BUSCTL, 8'h02);
    repeat (8) @(posedge clk);
    `CHK("cmd trigger pulls low", 1'b0, sda_oe_n)
    rreg(SBI_REG_BUSCTL);
    `CHK("cmd detect", 8'h08, v)
    wreg(SBI_REG_BUSCTL, 8'h01);
    repeat (8) @(posedge clk);
    `CHK("rel trigger releases", 1'b1, sda_oe_n)
    rreg(SBI_REG_BUSCTL);
    `CHK("trigger self clear", 8'h04, v)
    $display("test regs done");
  endtask : t_regs

  // address byte received, auto ack, busy then ready
  task automatic t_addr;
    reset_dut;
    wreg(SBI_REG_MODE, 8'h80);
    wreg(SBI_REG_BUSCTL, 8'ha0);
    wreg(SBI_REG_SHIFT, 8'hff);
    far.frame;
    rreg(SBI_REG_BUSCTL);
    `CHK("release and cmd flags", 2'b11, v[3:2])
    far.xfer(8'h5a, rx, ack);
    `CHK("ack seen", 1'b1, ack)
    `CHK("irq at ninth", 1'b1, irq)
    rreg(SBI_REG_BUSCTL);
    `CHK("ack detect", 1'b1, v[6])
    rreg(SBI_REG_SHIFT);
    `CHK("rx byte", 8'h5a, v)
    rreg(SBI_REG_STAT);
    `CHK("class address", 3'h5, v[2:0])
    far.clk1(lvl);
    `CHK("busy low", 1'b0, lvl)
    wreg(SBI_REG_BUSCTL, 8'h20);
    far.clk1(lvl);
    `CHK("ready high", 1'b1, lvl)
    $display("test addr done");
  endtask : t_addr

  // data byte, busy, then a held-back transmit
  task automatic t_busy;
    reset_dut;
    wreg(SBI_REG_MODE, 8'h80);
    wreg(SBI_REG_BUSCTL, 8'ha0);
    wreg(SBI_REG_SHIFT, 8'hff);
    far.xfer(8'h00, rx, ack);
    rreg(SBI_REG_STAT);
    `CHK("class data", 2'h0, v[2:1])
    far.clk1(lvl);
    `CHK("busy low", 1'b0, lvl)
    wreg(SBI_REG_SVA, 8'ha5);
    far.hold(1'b1);
    wreg(SBI_REG_SHIFT, 8'ha5);
    far.clk1(lvl); // a clock while the line is held low must not shift
    far.hold(1'b0);
    repeat (10) @(posedge clk);
    far.xfer(8'hff, rx, ack);
    `CHK("tx byte", 8'ha5, rx)
    rreg(SBI_REG_BUSCTL);
    `CHK("busy enable kept", 1'b1, v[7])
    rreg(SBI_REG_SHIFT);
    `CHK("line captured", 8'ha5, v)
    rreg(SBI_REG_MODE);
    `CHK("match flag", 1'b1, v[6])
    $display("test busy done");
  endtask : t_busy

  // wake-up: mismatch then match
  task automatic t_wake;
    for (int i = 0; i < 2; i++) begin
      reset_dut;
      wreg(SBI_REG_MODE, 8'ha0);
      wreg(SBI_REG_SVA, 8'h33);
      wreg(SBI_REG_SHIFT, 8'h00);
      far.frame;
      far.xfer(i[0] ? 8'h33 : 8'h5a, rx, ack);
      `CHK("wake irq", i[0], irq)
      `CHK("no auto ack", 1'b0, ack)
      rreg(SBI_REG_BUSCTL);
      `CHK("release flag", i[0], v[2])
      wreg(SBI_REG_BUSCTL, 8'h10);
      far.clk1(lvl);
      `CHK("ack by trigger", 1'b0, lvl)
    end
    $display("test wake done");
  endtask : t_wake

  // master mode: own clock, msb first, nine clocks then stop high
  task automatic t_master;
    int p0;
    reset_dut;
    far.hold(1'b0);
    p0 = n_pulse;
    wreg(SBI_REG_MODE, 8'h82);
    wreg(SBI_REG_SHIFT, 8'ha5);
    `CHK("clock driven", 1'b0, sck_oe_n)
    for (int i = 7; i >= 0; i--) begin
      @(posedge sck_o);
      rx[i] = line;
    end
    @(posedge sck_o);
    repeat (20) @(posedge clk);
    `CHK("master tx", 8'ha5, rx)
    `CHK("master flag", 1'b1, irq)
    `CHK("one pulse", 1, n_pulse - p0)
    `CHK("clock stops high", 1'b1, sck_o)
    `CHK("data pin low", 1'b0, sda_o)
    $display("test master done");
  endtask : t_master

  // release select: interrupt on release
  task automatic t_sic;
    reset_dut;
    wreg(SBI_REG_MODE, 8'ha0);
    wreg(SBI_REG_ITIME, 8'h20);
    far.frame;
    `CHK("irq on release", 1'b1, irq)
    $display("test sic done");
  endtask : t_sic

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    arst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    n_fail = 0;
    comparisons = 0;
    t_regs;
    t_addr;
    t_busy;
    t_wake;
    t_master;
    t_sic;
    end_of_test;
  end

  // watchdog well past the expected run
  initial begin
    #200000;
    n_fail++;
    end_of_test;
  end
endmodule : tb
